// [inc/ccsd_pkg.sv]
`default_nettype none
package ccsd_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] ADR_INSN = 8'h00;
   localparam logic [7:0] ADR_FLAGS = 8'h04;
   localparam logic [7:0] ADR_MODE = 8'h08;
   localparam logic [7:0] ADR_OPA = 8'h0C;
   localparam logic [7:0] ADR_OPB = 8'h10;
   localparam logic [7:0] ADR_OPADR = 8'h14;
   localparam logic [7:0] ADR_CTRL = 8'h18;
   localparam logic [7:0] ADR_STATUS = 8'h1C;
   localparam logic [7:0] ADR_RESULT = 8'h20;
   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int F_CF = 0;
   localparam int F_PF = 2;
   localparam int F_ZF = 6;
   localparam int F_SF = 7;
   localparam int F_IF = 9;
   localparam int F_DF = 10;
   localparam int F_OF = 11;
   localparam int F_IO_PRIVILEGE_LEVEL = 12;
   localparam int M_PROT = 0;
   localparam int M_CPL = 1;
   localparam int M_STACK = 3;
   localparam int M_LIMFLT = 4;
   localparam int M_SMM = 5;
   localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [31:0] REAL_LIMIT = 32'h0000_FFFF;
   // ----------------------------------------
   // exception vectors
   // ----------------------------------------
   localparam logic [7:0] VEC_NONE = 8'h00;
   localparam logic [7:0] VEC_BADOP = 8'h06;
   localparam logic [7:0] VEC_STACK = 8'h0C;
   localparam logic [7:0] VEC_GP = 8'h0D;
   // ----------------------------------------
   // opcode patterns
   // ----------------------------------------
   localparam logic [7:0] OPC_ESC = 8'h0F;
   localparam logic [7:0] OPC_DIR_SET = 8'hFD;
   localparam logic [7:0] OPC_INT_SET = 8'hFB;
   localparam logic [3:0] OPC_SETCC_HI = 4'h9;
   localparam logic [6:0] OPC_DSHL_HI = 7'h52;
   localparam logic [6:0] OPC_DSHR_HI = 7'h56;
   localparam logic [7:0] OPC_TBL_GRP = 8'h01;
   localparam logic [7:0] OPC_SEL_GRP = 8'h00;
   localparam logic [5:0] OPC_SBB_RM_HI = 6'h06;
   localparam logic [6:0] OPC_SBB_ACC_HI = 7'h0E;
   localparam logic [5:0] OPC_IMM_GRP_HI = 6'h20;
   localparam logic [6:0] OPC_SH_ONE_HI = 7'h68;
   localparam logic [6:0] OPC_SH_CL_HI = 7'h69;
   localparam logic [6:0] OPC_SH_IMM_HI = 7'h60;
   localparam logic [2:0] RF_SBB = 3'h3;
   localparam logic [2:0] RF_SHL = 3'h4;
   localparam logic [2:0] RF_SHR = 3'h5;
   localparam logic [2:0] RF_GDT = 3'h0;
   localparam logic [2:0] RF_IDT = 3'h1;
   localparam logic [2:0] RF_MSW = 3'h4;
   localparam logic [2:0] RF_LDT = 3'h0;
   localparam logic [1:0] MOD_REG = 2'h3;
   // ----------------------------------------
   // clock counts
   // ----------------------------------------
   localparam logic [3:0] CYC_1 = 4'h1;
   localparam logic [3:0] CYC_2 = 4'h2;
   localparam logic [3:0] CYC_3 = 4'h3;
   localparam logic [3:0] CYC_4 = 4'h4;
   localparam logic [3:0] CYC_5 = 4'h5;
   localparam logic [3:0] CYC_6 = 4'h6;
   localparam logic [3:0] CYC_8 = 4'h8;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [3:0] {
      OP_NONE, OP_SETCC, OP_SBB, OP_SHL, OP_SHR, OP_DSHL, OP_DSHR,
      OP_STORE_GLOBAL_TABLE_REG, OP_STORE_INTERRUPT_TABLE_REG, OP_SLDT, OP_STORE_MACHINE_STATUS_WORD, OP_STD, OP_STI
   } ccsd_op_t;
   typedef enum logic {ST_IDLE, ST_RUN} ccsd_state_t;
   // sign, zero and low-byte even parity of a result
   function automatic logic [2:0] ccsd_szp(input logic [31:0] v);
      return {v[31], v == WORD_RST, ~^v[7:0]};
   endfunction : ccsd_szp
endpackage : ccsd_pkg
`default_nettype wire

// [inc/ccsd_dec_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface ccsd_dec_if;
   import ccsd_pkg::*;
   logic [23:0] insn; // modrm, second byte, first byte
   ccsd_op_t op; // decoded operation
   logic is_mem; // memory operand
   logic [3:0] cycles; // clocks to run
   logic [2:0] len; // operand bytes
   logic chk_io; // gated on io privilege
   logic chk_priv0; // needs level 0 in protected mode
   logic prot_only; // protected mode only
   logic lock; // touches descriptor tables
   logic by_one; // shift count fixed at one
   modport dec (input insn, output op, is_mem, cycles, len, chk_io, chk_priv0, prot_only, lock, by_one);
   modport core (output insn, input op, is_mem, cycles, len, chk_io, chk_priv0, prot_only, lock, by_one);
endinterface : ccsd_dec_if
`default_nettype wire

// [rtl/ccsd_decode.sv]
`timescale 1ns/100ps
`default_nettype none
module ccsd_decode
   import ccsd_pkg::*;
(
   ccsd_dec_if.dec d
);
   logic [7:0] b0; // first opcode byte
   logic [7:0] b1; // second opcode byte
   logic [2:0] rf; // modrm reg field
   logic mem; // modrm selects memory
   assign b0 = d.insn[7:0];
   assign b1 = d.insn[15:8];
   assign rf = d.insn[21:19];
   assign mem = d.insn[23:22] != MOD_REG;

   // ----------------------------------------
   // opcode classification
   // ----------------------------------------
   always_comb begin
      d.op = OP_NONE;
      d.is_mem = 1'b0;
      d.cycles = CYC_1;
      d.len = 3'd0;
      d.chk_io = 1'b0;
      d.chk_priv0 = 1'b0;
      d.prot_only = 1'b0;
      d.lock = 1'b0;
      d.by_one = 1'b0;
      if (b0 == OPC_ESC) begin
         if (b1[7:4] == OPC_SETCC_HI) begin
            // conditional byte store, two clocks either way
            d.op = OP_SETCC;
            d.is_mem = mem;
            d.cycles = CYC_2;
            d.len = 3'd1;
         end else if (b1[7:1] == OPC_DSHL_HI || b1[7:1] == OPC_DSHR_HI) begin
            // double shifts, low bit picks count in cl
            d.op = (b1[7:1] == OPC_DSHL_HI) ? OP_DSHL : OP_DSHR;
            d.is_mem = mem;
            d.len = 3'd4;
            if (b1[0]) begin
               d.cycles = mem ? CYC_5 : CYC_3;
            end else begin
               d.cycles = mem ? CYC_3 : CYC_1;
            end
         end else if (b1 == OPC_TBL_GRP) begin
            d.is_mem = mem;
            unique case (rf)
               RF_GDT: begin
                  d.op = OP_STORE_GLOBAL_TABLE_REG;
                  d.cycles = CYC_6;
                  d.len = 3'd6;
                  d.lock = 1'b1;
               end
               RF_IDT: begin
                  d.op = OP_STORE_INTERRUPT_TABLE_REG;
                  d.cycles = CYC_8;
                  d.len = 3'd6;
                  d.lock = 1'b1;
               end
               RF_MSW: begin
                  d.op = OP_STORE_MACHINE_STATUS_WORD;
                  d.cycles = mem ? CYC_4 : CYC_2;
                  d.len = 3'd2;
                  d.chk_priv0 = 1'b1;
               end
               default: d.is_mem = 1'b0;
            endcase
         end else if (b1 == OPC_SEL_GRP && rf == RF_LDT) begin
            d.op = OP_SLDT;
            d.is_mem = mem;
            d.cycles = mem ? CYC_3 : CYC_2;
            d.len = 3'd2;
            d.prot_only = 1'b1;
            d.lock = 1'b1;
         end
      end else if (b0[7:2] == OPC_SBB_RM_HI || (b0[7:2] == OPC_IMM_GRP_HI && rf == RF_SBB)) begin
         d.op = OP_SBB;
         d.is_mem = mem;
         d.cycles = mem ? CYC_3 : CYC_1;
         d.len = b0[0] ? 3'd4 : 3'd1;
      end else if (b0[7:1] == OPC_SBB_ACC_HI) begin
         d.op = OP_SBB;
      end else if ((b0[7:2] == OPC_SH_ONE_HI[6:1] || b0[7:1] == OPC_SH_IMM_HI)
                   && (rf == RF_SHL || rf == RF_SHR)) begin
         d.op = (rf == RF_SHL) ? OP_SHL : OP_SHR;
         d.is_mem = mem;
         d.len = b0[0] ? 3'd4 : 3'd1;
         d.by_one = b0[7:1] == OPC_SH_ONE_HI;
         if (b0[7:1] == OPC_SH_CL_HI) begin
            d.cycles = mem ? CYC_4 : CYC_2;
         end else begin
            d.cycles = mem ? CYC_3 : CYC_1;
         end
      end else if (b0 == OPC_DIR_SET) begin
         d.op = OP_STD;
         d.cycles = CYC_2;
      end else if (b0 == OPC_INT_SET) begin
         d.op = OP_STI;
         d.cycles = CYC_4;
         d.chk_io = 1'b1;
      end
   end
endmodule : ccsd_decode
`default_nettype wire

// [rtl/ccsd_top.sv]
// Contract
// - 0F 90/91 store on overflow set/clear
// - 0F 92/93 store on carry set/clear
// - 0F 94/95 store on zero set/clear
// - 0F 96/97 store below-equal / above
// - 0F 98/99 store on sign set/clear
// - 0F 9A/9B store on parity even/odd
// - 0F 9C/9D store signed less / greater-equal
// - 0F 9E/9F store signed less-equal / greater
// - byte stores keep flags, take two clocks
// - FD sets direction flag, two clocks
// - FB sets interrupt flag, four clocks
// - level above io level gives vector 13
// - nonzero level on level-0 instruction: 13
// - real mode past FFFFh: 13, stack 12
// - protected limit/rights fault: 13, stack 12
// - protected-only instruction in real mode: 6
// - lock held during descriptor table cycles
// - descriptor table accesses assert lock automatically
// - system management accesses are noncacheable
// - subtract with borrow forms, 1/3 clocks
// - logical shifts use reg 100/101
// - double shifts 0F A4/A5/AC/AD
// - 0F 01 reg 001 table store, 100 status
`timescale 1ns/100ps
`default_nettype none
module ccsd_top
   import ccsd_pkg::*;
#(
   parameter int ADR_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic busy_o,
   output logic bus_lock_o,
   output logic noncacheable_o
);
   // ----------------------------------------
   // byte lane merge for register writes
   // ----------------------------------------
   function automatic logic [31:0] ccsd_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : ccsd_merge

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   ccsd_dec_if dif ();
   ccsd_state_t state_q; // execution state
   logic ack_q; // bus acknowledge
   logic [31:0] rdat_q; // registered read data
   logic [31:0] insn_q; // opcode bytes, modrm, count
   logic [31:0] flags_q; // flag word
   logic [31:0] mode_q; // mode, level, segment status
   logic [31:0] opa_q; // destination operand
   logic [31:0] opb_q; // source operand
   logic [31:0] adr_q; // operand offset
   logic [31:0] result_q; // value to write back
   logic [7:0] vec_q; // exception vector
   logic done_q; // sticky completion
   logic fault_q; // sticky exception
   logic [3:0] cnt_q; // clocks left
   logic lock_q; // bus lock output
   logic nc_q; // noncacheable output
   logic wr_en; // bus write this cycle
   logic acc; // bus access accepted
   logic go; // start request accepted
   logic finish; // last clock of execution
   logic [7:0] vec_d; // exception for pending start
   logic [31:0] res_d; // computed result
   logic [31:0] flags_d; // computed flags
   logic [4:0] count; // effective shift count
   logic cond; // byte store condition
   logic [32:0] end_adr; // last byte of operand
   logic prot; // protected mode
   logic [1:0] current_privilege_level; // current privilege level
   logic [1:0] io_privilege_level; // io privilege level
   logic clr; // status clear write this cycle

   assign dif.insn = insn_q[23:0];
   assign acc = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_en = acc && wb_we_i;
   assign go = wr_en && wb_adr_i == ADR_CTRL && wb_sel_i[0] && wb_dat_i[0] && state_q == ST_IDLE;
   assign finish = state_q == ST_RUN && cnt_q == 4'h0;
   assign prot = mode_q[M_PROT];
   assign current_privilege_level = mode_q[M_CPL +: 2];
   assign io_privilege_level = flags_q[F_IO_PRIVILEGE_LEVEL +: 2];

   // ----------------------------------------
   // decoder
   // ----------------------------------------
   ccsd_decode u_dec (
      .d(dif.dec)
   );

   // ----------------------------------------
   // byte store condition
   // ----------------------------------------
   always_comb begin
      logic base;
      base = 1'b0;
      unique case (insn_q[11:9])
         3'h0: base = flags_q[F_OF];
         3'h1: base = flags_q[F_CF];
         3'h2: base = flags_q[F_ZF];
         3'h3: base = flags_q[F_CF] | flags_q[F_ZF];
         3'h4: base = flags_q[F_SF];
         3'h5: base = flags_q[F_PF];
         3'h6: base = flags_q[F_SF] ^ flags_q[F_OF];
         3'h7: base = flags_q[F_ZF] | (flags_q[F_SF] ^ flags_q[F_OF]);
      endcase
      // odd opcodes test the complement
      cond = base ^ insn_q[8];
   end

   // ----------------------------------------
   // fault checks for a pending start
   // ----------------------------------------
   always_comb begin
      end_adr = {1'b0, adr_q} + {30'h0, dif.len} - 33'd1;
      vec_d = VEC_NONE;
      if (dif.op == OP_NONE) begin
         // unknown opcode reports invalid opcode
         vec_d = VEC_BADOP;
      end else if (dif.prot_only && !prot) begin
         vec_d = VEC_BADOP;
      end else if (dif.chk_io && prot && current_privilege_level > io_privilege_level) begin
         vec_d = VEC_GP;
      end else if (dif.chk_priv0 && prot && current_privilege_level != 2'd0) begin
         vec_d = VEC_GP;
      end else if (dif.is_mem && !prot && end_adr > {1'b0, REAL_LIMIT}) begin
         vec_d = mode_q[M_STACK] ? VEC_STACK : VEC_GP;
      end else if (dif.is_mem && prot && mode_q[M_LIMFLT]) begin
         vec_d = mode_q[M_STACK] ? VEC_STACK : VEC_GP;
      end
   end

   // ----------------------------------------
   // datapath: result and flags
   // ----------------------------------------
   always_comb begin
      logic [32:0] w33;
      logic [64:0] w65;
      w33 = 33'd0;
      w65 = 65'd0;
      res_d = opa_q;
      flags_d = flags_q;
      count = dif.by_one ? 5'd1 : insn_q[28:24];
      unique case (dif.op)
         OP_SETCC: begin
            // flags stay as they are
            res_d = {31'h0, cond};
         end
         OP_SBB: begin
            w33 = {1'b0, opa_q} - {1'b0, opb_q} - {32'h0, flags_q[F_CF]};
            res_d = w33[31:0];
            flags_d[F_CF] = w33[32];
            flags_d[F_OF] = (opa_q[31] ^ opb_q[31]) & (opa_q[31] ^ w33[31]);
            {flags_d[F_SF], flags_d[F_ZF], flags_d[F_PF]} = ccsd_szp(w33[31:0]);
         end
         OP_SHL, OP_SHR: begin
            if (dif.op == OP_SHL) begin
               w33 = {1'b0, opa_q} << count;
               res_d = w33[31:0];
               flags_d[F_CF] = w33[32];
               flags_d[F_OF] = w33[31] ^ w33[32];
            end else begin
               w33 = {opa_q, 1'b0} >> count;
               res_d = w33[32:1];
               flags_d[F_CF] = w33[0];
               flags_d[F_OF] = opa_q[31];
            end
            {flags_d[F_SF], flags_d[F_ZF], flags_d[F_PF]} = ccsd_szp(res_d);
            if (count == 5'd0) begin
               // zero count changes nothing
               res_d = opa_q;
               flags_d = flags_q;
            end
         end
         OP_DSHL, OP_DSHR: begin
            if (dif.op == OP_DSHL) begin
               w65 = {1'b0, opa_q, opb_q} << count;
               res_d = w65[63:32];
               flags_d[F_CF] = w65[64];
            end else begin
               w65 = {opb_q, opa_q, 1'b0} >> count;
               res_d = w65[32:1];
               flags_d[F_CF] = w65[0];
            end
            {flags_d[F_SF], flags_d[F_ZF], flags_d[F_PF]} = ccsd_szp(res_d);
            if (count == 5'd0) begin
               res_d = opa_q;
               flags_d = flags_q;
            end
         end
         OP_STORE_MACHINE_STATUS_WORD, OP_SLDT: res_d = {16'h0, opa_q[15:0]};
         OP_STD: flags_d[F_DF] = 1'b1;
         OP_STI: flags_d[F_IF] = 1'b1;
         default: res_d = opa_q;
      endcase
   end

   // ----------------------------------------
   // bus acknowledge, one wait state
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc;
      end
   end

   // ----------------------------------------
   // read data mux, unmapped reads zero
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= WORD_RST;
      end else if (acc && !wb_we_i) begin
         case (wb_adr_i)
            ADR_INSN: rdat_q <= insn_q;
            ADR_FLAGS: rdat_q <= flags_q;
            ADR_MODE: rdat_q <= mode_q;
            ADR_OPA: rdat_q <= opa_q;
            ADR_OPB: rdat_q <= opb_q;
            ADR_OPADR: rdat_q <= adr_q;
            ADR_STATUS: rdat_q <= {12'h0, dif.op, vec_q, 5'h0, fault_q, done_q, state_q == ST_RUN};
            ADR_RESULT: rdat_q <= result_q;
            default: rdat_q <= WORD_RST;
         endcase
      end else begin
         rdat_q <= WORD_RST;
      end
   end

   // ----------------------------------------
   // operand registers, frozen while running
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         insn_q <= WORD_RST;
         mode_q <= WORD_RST;
         opa_q <= WORD_RST;
         opb_q <= WORD_RST;
         adr_q <= WORD_RST;
      end else if (wr_en && state_q == ST_IDLE) begin
         if (wb_adr_i == ADR_INSN) begin
            insn_q <= ccsd_merge(insn_q, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == ADR_MODE) begin
            mode_q <= ccsd_merge(mode_q, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == ADR_OPA) begin
            opa_q <= ccsd_merge(opa_q, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == ADR_OPB) begin
            opb_q <= ccsd_merge(opb_q, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == ADR_OPADR) begin
            adr_q <= ccsd_merge(adr_q, wb_dat_i, wb_sel_i);
         end
      end
   end

   // ----------------------------------------
   // flag word: software write or retirement
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_q <= FLAGS_RST;
      end else if (finish) begin
         flags_q <= flags_d;
      end else if (wr_en && state_q == ST_IDLE && wb_adr_i == ADR_FLAGS) begin
         flags_q <= ccsd_merge(flags_q, wb_dat_i, wb_sel_i);
      end
   end

   // ----------------------------------------
   // execution sequencer
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               // a faulting start never runs
               if (go && vec_d == VEC_NONE) begin
                  state_q <= ST_RUN;
                  cnt_q <= dif.cycles - CYC_1;
               end
            end
            ST_RUN: begin
               if (cnt_q == 4'h0) begin
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // result and exception capture
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_q <= WORD_RST;
         vec_q <= VEC_NONE;
      end else if (go) begin
         vec_q <= vec_d;
      end else if (finish) begin
         result_q <= res_d;
      end
   end

   // ----------------------------------------
   // sticky status, set wins over clear
   // ----------------------------------------
   assign clr = wr_en && wb_adr_i == ADR_STATUS && wb_sel_i[0];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_q <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         if (finish || (go && vec_d != VEC_NONE)) begin
            done_q <= 1'b1;
         end else if (clr && wb_dat_i[1]) begin
            done_q <= 1'b0;
         end
         if (go && vec_d != VEC_NONE) begin
            fault_q <= 1'b1;
         end else if (clr && wb_dat_i[2]) begin
            fault_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // bus lock and cacheability attributes
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_q <= 1'b0;
         nc_q <= 1'b0;
      end else if (go && vec_d == VEC_NONE) begin
         lock_q <= dif.lock;
         nc_q <= mode_q[M_SMM] && dif.is_mem;
      end else if (finish) begin
         lock_q <= 1'b0;
         nc_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign busy_o = state_q == ST_RUN;
   assign bus_lock_o = lock_q;
   assign noncacheable_o = nc_q;
endmodule : ccsd_top
`default_nettype wire

// [test/ccsd_props.sv]
`timescale 1ns/100ps
`default_nettype none
module ccsd_props
   import ccsd_pkg::*;
#(parameter int ADR_W = 8) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic busy_o,
   input wire logic bus_lock_o,
   input wire logic noncacheable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a request waiting for its answer
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   a_ack_next: assert property (s_req |=> wb_ack_o) else $error("no ack after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == WORD_RST) else $error("read data outside ack");
   a_busy_cause: assert property ($rose(busy_o) |-> $past(wb_we_i && wb_adr_i == ADR_CTRL))
      else $error("busy without start write");
   a_busy_short: assert property ($rose(busy_o) |-> ##[1:8] !busy_o) else $error("busy too long");
   a_lock_busy: assert property (bus_lock_o |-> busy_o) else $error("lock while idle");
   a_lock_end: assert property ($fell(busy_o) |-> !bus_lock_o) else $error("lock after end");
   a_nc_busy: assert property (noncacheable_o |-> busy_o) else $error("noncacheable idle");
endmodule : ccsd_props
bind ccsd_top ccsd_props #(.ADR_W(ADR_W)) i_ccsd_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy_o, .bus_lock_o, .noncacheable_o);
`default_nettype wire

// [test/ccsd_wb_master.sv]
`timescale 1ns/100ps
`default_nettype none
module ccsd_wb_master (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   initial begin
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
   end
   // one classic cycle, held until ack is sampled
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'h3, w, a, 4'hF, d};
      do @(posedge clk_i); while (ack_i !== 1'b1);
      r = dat_i;
      {cyc_o, stb_o, we_o} <= 3'h0;
   endtask : xfer
endmodule : ccsd_wb_master
`default_nettype wire

// [test/ccsd_top_test.sv]
`timescale 1ns/100ps
`default_nettype none
module ccsd_top_test
   import ccsd_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack, busy, lock, nc;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, v, f;
   logic [1:0] lk;
   int bad_count = 0, check_count = 0, cyc_n = 0, bn = 0, last_n = 0;
   ccsd_top i_ccsd_top (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(busy), .bus_lock_o(lock),
      .noncacheable_o(nc));
   ccsd_wb_master i_ccsd_wb_master (.clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   initial forever #50 clk_i = ~clk_i;
   // busy length, lock and noncacheable seen, timeout
   always @(posedge clk_i) begin
      cyc_n++;
      if (busy) bn++;
      else if (bn != 0) begin last_n = bn; bn = 0; end
      if (lock === 1'b1) lk[0] = 1'b1;
      if (nc === 1'b1) lk[1] = 1'b1;
      if (cyc_n == 20000) begin bad_count++; final_report(); end
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin bad_count++; $display("mismatch %s expected %h seen %h", nm, exp, seen); end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [31:0] d);
      i_ccsd_wb_master.xfer(1'b1, a, d, v);
   endtask : wr
   // model of the byte-set condition table
   function automatic logic cc(logic [3:0] c, logic [31:0] x);
      logic [7:0] b;
      b = {x[F_ZF] | (x[F_SF] ^ x[F_OF]), x[F_SF] ^ x[F_OF], x[F_PF], x[F_SF], x[F_CF] | x[F_ZF], x[F_ZF],
         x[F_CF], x[F_OF]};
      return b[c[3:1]] ^ c[0];
   endfunction : cc
   // program, start, wait, compare vector, clocks, lock and flags
   task automatic run(logic [23:0] ins, logic [31:0] fl, md, oa, logic [7:0] vec, int n, logic [1:0] el,
      logic [31:0] ef);
      wr(ADR_INSN, {8'h04, ins}); // shift count of four rides along
      wr(ADR_FLAGS, fl);
      wr(ADR_MODE, md);
      wr(ADR_OPADR, oa);
      last_n = 0;
      lk = 2'h0;
      wr(ADR_CTRL, 32'h1);
      do i_ccsd_wb_master.xfer(1'b0, ADR_STATUS, 32'h0, v); while (v[0] !== 1'b0);
      chk("vector", {24'h0, v[15:8]}, {24'h0, vec});
      chk("clocks", last_n, n);
      chk("lock", {30'h0, lk}, {30'h0, el});
      i_ccsd_wb_master.xfer(1'b0, ADR_FLAGS, 32'h0, v);
      chk("flags", v, ef);
      wr(ADR_STATUS, 32'h6);
   endtask : run
   // load both operands, run in real mode, compare the result
   task automatic alu(logic [23:0] ins, logic [31:0] fl, oa, ob, int n, logic [31:0] ef, er);
      wr(ADR_OPA, oa);
      wr(ADR_OPB, ob);
      run(ins, fl, 32'h0, 32'h0, VEC_NONE, n, 2'h0, ef);
      i_ccsd_wb_master.xfer(1'b0, ADR_RESULT, 32'h0, v);
      chk("result", v, er);
   endtask : alu
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : final_report
   initial begin
      void'($urandom(17));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int c = 0; c < 16; c++) begin
         f = ($urandom & 32'hEC5) | 32'h2;
         run({8'hC0, 4'h9, 4'(c), 8'h0F}, f, 32'h0, 32'h0, VEC_NONE, 2, 2'h0, f);
         i_ccsd_wb_master.xfer(1'b0, ADR_RESULT, 32'h0, v);
         chk("setcc", v, {31'h0, cc(4'(c), f)});
      end
      run(24'h0000FD, 32'h2, 32'h0, 32'h0, VEC_NONE, 2, 2'h0, 32'h402);
      run(24'h0000FB, 32'h2, 32'h0, 32'h0, VEC_NONE, 4, 2'h0, 32'h202);
      run(24'h0000FB, 32'h1002, 32'h3, 32'h0, VEC_NONE, 4, 2'h0, 32'h1202);
      run(24'h0000FB, 32'h2, 32'h3, 32'h0, VEC_GP, 0, 2'h0, 32'h2);
      run(24'hE0010F, 32'h2, 32'h3, 32'h0, VEC_GP, 0, 2'h0, 32'h2);
      run(24'h08010F, 32'h2, 32'h21, 32'h0, VEC_NONE, 8, 2'h3, 32'h2);
      run(24'h00940F, 32'h2, 32'h0, 32'hFFFF, VEC_NONE, 2, 2'h0, 32'h2);
      run(24'h00940F, 32'h2, 32'h0, 32'h10000, VEC_GP, 0, 2'h0, 32'h2);
      run(24'h00940F, 32'h2, 32'h8, 32'h10000, VEC_STACK, 0, 2'h0, 32'h2);
      run(24'h00940F, 32'h2, 32'h11, 32'h0, VEC_GP, 0, 2'h0, 32'h2);
      run(24'h00940F, 32'h2, 32'h19, 32'h0, VEC_STACK, 0, 2'h0, 32'h2);
      run(24'hC0000F, 32'h2, 32'h0, 32'h0, VEC_BADOP, 0, 2'h0, 32'h2);
      alu(24'hC00019, 32'h3, 32'h5, 32'h7, 1, 32'h83, 32'hFFFFFFFD);
      alu(24'hE000D1, 32'h2, 32'h80000001, 32'h0, 1, 32'h803, 32'h2);
      alu(24'hE800D3, 32'h2, 32'h80000010, 32'h0, 2, 32'h802, 32'h08000001);
      alu(24'hC0A40F, 32'h2, 32'h12345678, 32'h9ABCDEF0, 1, 32'h3, 32'h23456789);
      alu(24'hC0AD0F, 32'h2, 32'h12345678, 32'h9ABCDEF0, 3, 32'h3, 32'h01234567);
      alu(24'hE0010F, 32'h2, 32'h1234ABCD, 32'h0, 2, 32'h2, 32'h0000ABCD);
      i_ccsd_wb_master.xfer(1'b0, 8'hF0, 32'h0, v);
      chk("unmapped", v, 32'h0);
      final_report();
   end
endmodule : ccsd_top_test
`default_nettype wire
